//--- hw/pcr_map.vh
// Constants for the port configuration read-back command decoder
// Function
// - Direction read command returns code plus register
// - Pull-up read command returns code plus register
// - Threshold read command returns code plus register
// - Port A Schmitt read returns code plus register
// - Threshold bit 0 is 2.5V; reset 255
// - Schmitt bit 0 is on; reset 255
`ifndef PCR_MAP_VH
`define PCR_MAP_VH

// Command lead characters, shared by command and reply
`define PCR_CH_DIR 8'h21
`define PCR_CH_PULL 8'h40
`define PCR_CH_THR 8'h23
`define PCR_CH_SCH 8'h24

// Port letters: lower case in the command, upper case in the reply
`define PCR_CH_LOW_A 8'h61
`define PCR_CH_UP_A 8'h41
`define PCR_PORT_COUNT 2'h3

// Register kinds, as used in the register index kind*3+port
`define PCR_KIND_DIR 2'h0
`define PCR_KIND_PULL 2'h1
`define PCR_KIND_THR 2'h2
`define PCR_KIND_SCH 2'h3
`define PCR_REG_COUNT 12
`define PCR_IDX_W 4

// Power-up values of each register kind
`define PCR_RST_DIR 8'hFF
`define PCR_RST_PULL 8'h00
`define PCR_RST_THR 8'hFF
`define PCR_RST_SCH 8'hFF

// Length of a command and of a reply, in bytes
`define PCR_CMD_LEN 2'h2
`define PCR_RSP_LEN 2'h3

`endif

//--- hw/pcr_cfg_mem.v
// Twelve 8-bit port configuration registers with a registered read port
`timescale 1ns/10ps
`include "pcr_map.vh"

module pcr_cfg_mem (
   input wire clk_in,
   input wire sys_rst_in,
   input wire wr_en_in,
   input wire [3:0] wr_idx_in,
   input wire [7:0] wr_data_in,
   input wire [3:0] rd_idx_in,
   output reg [7:0] rd_data_out,
   output wire [23:0] thr_sel_out,
   output wire [23:0] sch_off_out
);

   reg [7:0] mem [0:`PCR_REG_COUNT-1];
   integer i;

   // Power-up value of a register from its kind (upper index range)
   function [7:0] pcr_rst_val;
      input integer idx;
      begin
         if (idx < 3) begin
            pcr_rst_val = `PCR_RST_DIR;
         end else if (idx < 6) begin
            pcr_rst_val = `PCR_RST_PULL;
         end else if (idx < 9) begin
            pcr_rst_val = `PCR_RST_THR;
         end else begin
            pcr_rst_val = `PCR_RST_SCH;
         end
      end
   endfunction

   // Storage: only reset and the write port change a register, never a read
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         for (i = 0; i < `PCR_REG_COUNT; i = i + 1) begin
            mem[i] <= pcr_rst_val(i);
         end
      end else if (wr_en_in && (wr_idx_in < `PCR_REG_COUNT)) begin
         mem[wr_idx_in] <= wr_data_in;
      end
   end

   // Registered read; an out-of-range index reads zero
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_data_out <= 8'h00;
      end else if (rd_idx_in < `PCR_REG_COUNT) begin
         rd_data_out <= mem[rd_idx_in];
      end else begin
         rd_data_out <= 8'h00;
      end
   end

   // Line controls: threshold 1 = 1.4V, 0 = 2.5V; Schmitt 1 = off, 0 = on
   assign thr_sel_out = {mem[8], mem[7], mem[6]};
   assign sch_off_out = {mem[11], mem[10], mem[9]};

endmodule

//--- hw/pcr_readback.v
// Command decoder answering configuration register read-back requests
`timescale 1ns/10ps
`include "pcr_map.vh"

module pcr_readback (
   input wire clk_in,
   input wire sys_rst_in,
   input wire [7:0] cmd_byte_in,
   input wire cmd_valid_in,
   input wire cmd_start_in,
   output reg cmd_ready_out,
   output reg [7:0] rsp_byte_out,
   output reg rsp_valid_out,
   output reg rsp_last_out,
   input wire rsp_ready_in,
   input wire cfg_wr_en_in,
   input wire [3:0] cfg_wr_idx_in,
   input wire [7:0] cfg_wr_data_in,
   output wire [23:0] thr_sel_out,
   output wire [23:0] sch_off_out,
   output reg busy_out
);

   ////////////////////////////////////////////////////////////////////////////
   // States
   localparam ST_IDLE = 3'h0;
   localparam ST_GOT1 = 3'h1;
   localparam ST_READ = 3'h2;
   localparam ST_LOAD = 3'h3;
   localparam ST_SEND = 3'h4;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [1:0] kind;
   reg [1:0] next_kind;
   reg [7:0] lead;
   reg [7:0] next_lead;
   reg [1:0] port;
   reg [1:0] next_port;
   reg [3:0] rd_idx;
   reg [3:0] next_rd_idx;
   reg [1:0] sent;
   reg [7:0] held_val;
   wire [7:0] rd_data;
   wire [2:0] kind_dec;
   wire [2:0] port_dec;
   wire byte_take;
   wire rsp_take;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Lead character to {valid, kind}
   function [2:0] pcr_kind;
      input [7:0] ch;
      begin
         case (ch)
            `PCR_CH_DIR: pcr_kind = {1'b1, `PCR_KIND_DIR};
            `PCR_CH_PULL: pcr_kind = {1'b1, `PCR_KIND_PULL};
            `PCR_CH_THR: pcr_kind = {1'b1, `PCR_KIND_THR};
            `PCR_CH_SCH: pcr_kind = {1'b1, `PCR_KIND_SCH};
            default: pcr_kind = 3'h0;
         endcase
      end
   endfunction

   // Lower-case port letter to {valid, port number}
   function [2:0] pcr_port;
      input [7:0] ch;
      reg [7:0] d;
      begin
         d = ch - `PCR_CH_LOW_A;
         if (d < {6'h00, `PCR_PORT_COUNT}) begin
            pcr_port = {1'b1, d[1:0]};
         end else begin
            pcr_port = 3'h0;
         end
      end
   endfunction

   // Register index from kind and port
   function [3:0] pcr_index;
      input [1:0] k;
      input [1:0] p;
      begin
         pcr_index = ({2'h0, k} << 1) + {2'h0, k} + {2'h0, p};
      end
   endfunction

   // Decoded command byte, split into flag and field so nothing is cut silently
   assign kind_dec = pcr_kind(cmd_byte_in);
   assign port_dec = pcr_port(cmd_byte_in);
   assign byte_take = cmd_valid_in && cmd_ready_out;
   assign rsp_take = rsp_valid_out && rsp_ready_in;

   ////////////////////////////////////////////////////////////////////////////
   // Register store; the read path has one cycle of latency

   pcr_cfg_mem u_mem (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .wr_en_in(cfg_wr_en_in),
      .wr_idx_in(cfg_wr_idx_in),
      .wr_data_in(cfg_wr_data_in),
      .rd_idx_in(rd_idx),
      .rd_data_out(rd_data),
      .thr_sel_out(thr_sel_out),
      .sch_off_out(sch_off_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Command parser and reply sequencer, next-state logic
   // Unknown commands and Schmitt reads of ports B and C get no reply
   always @* begin
      next_state = state;
      next_kind = kind;
      next_lead = lead;
      next_port = port;
      next_rd_idx = rd_idx;
      case (state)
         ST_IDLE: begin
            if (byte_take && cmd_start_in && kind_dec[2]) begin
               next_kind = kind_dec[1:0];
               next_lead = cmd_byte_in;
               next_state = ST_GOT1;
            end
         end
         ST_GOT1: begin
            if (byte_take) begin
               if (cmd_start_in) begin
                  // A fresh packet with a known lead restarts the parse with that lead byte; an unknown lead drops it
                  if (kind_dec[2]) begin
                     next_kind = kind_dec[1:0];
                     next_lead = cmd_byte_in;
                  end else begin
                     next_state = ST_IDLE;
                  end
               end else if (!port_dec[2]) begin
                  next_state = ST_IDLE;
               end else if (kind == `PCR_KIND_SCH && port_dec != 3'h4) begin
                  next_state = ST_IDLE;
               end else begin
                  next_port = port_dec[1:0];
                  next_rd_idx = pcr_index(kind, port_dec[1:0]);
                  next_state = ST_READ;
               end
            end
         end
         ST_READ: begin
            next_state = ST_LOAD;
         end
         ST_LOAD: begin
            next_state = ST_SEND;
         end
         ST_SEND: begin
            if (rsp_take && rsp_last_out) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parser state
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         kind <= `PCR_KIND_DIR;
         lead <= 8'h00;
         port <= 2'h0;
         rd_idx <= 4'h0;
         cmd_ready_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         state <= next_state;
         kind <= next_kind;
         lead <= next_lead;
         port <= next_port;
         rd_idx <= next_rd_idx;
         // Commands are held off while a reply is pending, so none is lost
         cmd_ready_out <= (next_state == ST_IDLE) || (next_state == ST_GOT1);
         busy_out <= (next_state != ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reply bytes: lead, upper-case port letter, then register value
   // The value is captured once so a later write cannot tear the reply
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rsp_byte_out <= 8'h00;
         rsp_valid_out <= 1'b0;
         rsp_last_out <= 1'b0;
         sent <= 2'h0;
         held_val <= 8'h00;
      end else if (state == ST_LOAD) begin
         held_val <= rd_data;
         rsp_byte_out <= lead;
         rsp_valid_out <= 1'b1;
         rsp_last_out <= 1'b0;
         sent <= 2'h0;
      end else if (rsp_take) begin
         if (rsp_last_out) begin
            rsp_valid_out <= 1'b0;
            rsp_last_out <= 1'b0;
            rsp_byte_out <= 8'h00;
         end else if (sent == 2'h0) begin
            rsp_byte_out <= `PCR_CH_UP_A + {6'h00, port};
            sent <= 2'h1;
         end else begin
            rsp_byte_out <= held_val;
            rsp_last_out <= 1'b1;
            sent <= `PCR_RSP_LEN - 2'h1;
         end
      end
   end

endmodule

//--- bench/pcr_readback_chk.sv
// Checker for the read-back decoder ports
`timescale 1ns/10ps
`include "pcr_map.vh"
module pcr_readback_chk (
   input wire clk_in,
   input wire sys_rst_in,
   input wire [7:0] cmd_byte_in,
   input wire cmd_valid_in,
   input wire cmd_start_in,
   input wire cmd_ready_out,
   input wire [7:0] rsp_byte_out,
   input wire rsp_valid_out,
   input wire rsp_last_out,
   input wire rsp_ready_in,
   input wire cfg_wr_en_in,
   input wire [3:0] cfg_wr_idx_in,
   input wire [7:0] cfg_wr_data_in,
   input wire [23:0] thr_sel_out,
   input wire [23:0] sch_off_out,
   input wire busy_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////////////////////////
   // Reply framing
   lead_byte_a: assert property ($rose(rsp_valid_out) |-> !rsp_last_out &&
      rsp_byte_out inside {`PCR_CH_DIR, `PCR_CH_PULL, `PCR_CH_THR, `PCR_CH_SCH})
      else $error("reply lead byte wrong");
   reply_hold_a: assert property (rsp_valid_out && !rsp_ready_in |=>
      rsp_valid_out && $stable(rsp_byte_out) && $stable(rsp_last_out))
      else $error("reply byte dropped");
   last_end_a: assert property (rsp_valid_out && rsp_ready_in && rsp_last_out |=>
      !rsp_valid_out && cmd_ready_out) else $error("reply did not end");
   // Port letter a always has a reply, whatever the lead
   answer_time_a: assert property (cmd_valid_in && cmd_ready_out && busy_out &&
      !cmd_start_in && cmd_byte_in == `PCR_CH_LOW_A |-> ##[3:4] rsp_valid_out)
      else $error("reply late");
   no_accept_a: assert property (rsp_valid_out |-> !cmd_ready_out)
      else $error("command taken during reply");
   ////////////////////////////////////////////////////////////
   // Configuration lines
   thr_write_a: assert property (cfg_wr_en_in && cfg_wr_idx_in == 4'h6 |=>
      thr_sel_out[7:0] == $past(cfg_wr_data_in)) else $error("threshold lines wrong");
   sch_write_a: assert property (cfg_wr_en_in && cfg_wr_idx_in == 4'h9 |=>
      sch_off_out[7:0] == $past(cfg_wr_data_in)) else $error("schmitt lines wrong");
   lines_kept_a: assert property (!cfg_wr_en_in |=>
      $stable(thr_sel_out) && $stable(sch_off_out)) else $error("lines moved");
   cover property (rsp_valid_out && rsp_ready_in && rsp_last_out);
   cover property (rsp_valid_out && !rsp_ready_in);
   cover property (cfg_wr_en_in && cfg_wr_idx_in == 4'h6);
endmodule
bind pcr_readback pcr_readback_chk chk_u (.clk_in, .sys_rst_in, .cmd_byte_in, .cmd_valid_in,
   .cmd_start_in, .cmd_ready_out, .rsp_byte_out, .rsp_valid_out, .rsp_last_out, .rsp_ready_in,
   .cfg_wr_en_in, .cfg_wr_idx_in, .cfg_wr_data_in, .thr_sel_out, .sch_off_out, .busy_out);

//--- bench/pcr_host_model.sv
// Host side model that takes reply bytes promptly or with random stalls
`timescale 1ns/10ps
module pcr_host_model (
   input wire clk_in,
   input wire sys_rst_in,
   input wire slow_in,
   output reg rsp_ready_out
);
   initial rsp_ready_out = 1'b0;
   // Stalls prove that each reply byte waits until taken
   always @(posedge clk_in) begin
      rsp_ready_out <= #1 !sys_rst_in && (!slow_in || $urandom_range(1, 0) == 1);
   end
endmodule

//--- bench/port_config_readback_tb_top.sv
// Self-checking bench for the read-back decoder
`timescale 1ns/10ps
`include "pcr_map.vh"
module port_config_readback_tb_top;
   reg clk_in = 0;
   reg sys_rst_in = 1;
   reg [7:0] cmd_byte_in = 0;
   reg cmd_valid_in = 0;
   reg cmd_start_in = 0;
   reg cfg_wr_en_in = 0;
   reg [3:0] cfg_wr_idx_in = 0;
   reg [7:0] cfg_wr_data_in = 0;
   reg slow = 0;
   wire cmd_ready_out, rsp_valid_out, rsp_last_out, rsp_ready_in, busy_out;
   wire [7:0] rsp_byte_out;
   wire [23:0] thr_sel_out, sch_off_out;
   wire [31:0] lead_tab = {`PCR_CH_SCH, `PCR_CH_THR, `PCR_CH_PULL, `PCR_CH_DIR};
   integer bad_count = 0;
   integer n_tests = 0;
   integer k, p, r;
   reg [7:0] val;
   reg [7:0] shadow [0:11];
   reg [23:0] thr, sch;
   reg [8:0] exp_q[$];
   always #50 clk_in = ~clk_in;
   pcr_readback dut_u (.clk_in, .sys_rst_in, .cmd_byte_in, .cmd_valid_in, .cmd_start_in,
      .cmd_ready_out, .rsp_byte_out, .rsp_valid_out, .rsp_last_out, .rsp_ready_in,
      .cfg_wr_en_in, .cfg_wr_idx_in, .cfg_wr_data_in, .thr_sel_out, .sch_off_out, .busy_out);
   pcr_host_model host_u (.clk_in, .sys_rst_in, .slow_in(slow), .rsp_ready_out(rsp_ready_in));
   ////////////////////////////////////////////////////////////
   task check(input [23:0] seen, input [23:0] want, input string what);
      n_tests++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value %0s expected %h seen %h", what, want, seen);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Valid stays up between bytes, so the caller lowers it
   task put(input [7:0] b, input s);
      integer i;
      cmd_byte_in = b;
      cmd_start_in = s;
      cmd_valid_in = 1;
      for (i = 0; i < 50 && cmd_ready_out !== 1'b1; i++) @(posedge clk_in) #1;
      if (i >= 50) begin
         bad_count++;
         tally_and_finish;
      end
      @(posedge clk_in) #1;
   endtask
   // Sends one command; ok says whether a reply is owed
   task cmd(input [7:0] lead, input [7:0] letter, input [7:0] v, input ok);
      integer i;
      if (ok) begin
         exp_q.push_back({1'b0, lead});
         exp_q.push_back({1'b0, letter - 8'h20});
         exp_q.push_back({1'b1, v});
      end
      put(lead, 1);
      put(letter, 0);
      check(busy_out, ok, "busy");
      cmd_valid_in = 0;
      for (i = 0; i < 300 && (busy_out !== 1'b0 || exp_q.size() != 0); i++) @(posedge clk_in) #1;
      if (i >= 300) begin
         bad_count++;
         tally_and_finish;
      end
      // Quiet gap so a stray reply is seen
      repeat (6) @(posedge clk_in) #1;
   endtask
   ////////////////////////////////////////////////////////////
   // Every reply byte taken must be the oldest expected one
   always @(posedge clk_in) begin
      if (rsp_valid_out === 1'b1 && rsp_ready_in === 1'b1) begin
         if (exp_q.size() == 0) check(1, 0, "stray reply");
         else check({rsp_last_out, rsp_byte_out}, exp_q.pop_front(), "reply");
      end
   end
   initial begin
      r = $urandom(32'h31DA);
      repeat (2) @(posedge clk_in);
      #1 sys_rst_in = 0;
      check(thr_sel_out, 24'hFFFFFF, "thr reset");
      check(sch_off_out, 24'hFFFFFF, "sch reset");
      cmd(`PCR_CH_DIR, 8'h62, `PCR_RST_DIR, 1);
      cmd(`PCR_CH_PULL, 8'h63, `PCR_RST_PULL, 1);
      cmd(`PCR_CH_THR, 8'h61, `PCR_RST_THR, 1);
      cmd(`PCR_CH_SCH, 8'h61, `PCR_RST_SCH, 1);
      // All kinds and ports, second pass with a stalling host
      for (k = 0; k < 24; k++) begin
         slow = k >= 12;
         p = k % 3;
         val = $urandom;
         cfg_wr_idx_in = k % 12;
         cfg_wr_data_in = val;
         shadow[k % 12] = val;
         cfg_wr_en_in = 1;
         @(posedge clk_in) #1;
         cfg_wr_en_in = 0;
         thr = thr_sel_out;
         sch = sch_off_out;
         if (k % 12 / 3 == 2) check(thr[p * 8 +: 8], val, "thr bits");
         if (k % 12 / 3 == 3) check(sch[p * 8 +: 8], val, "sch bits");
         cmd(lead_tab[k % 12 / 3 * 8 +: 8], 8'h61 + p, val, k % 12 < 10);
         check(thr_sel_out, thr, "thr kept");
         check(sch_off_out, sch, "sch kept");
      end
      // Bad port letter and unknown lead get no reply
      cmd(`PCR_CH_DIR, 8'h7A, 0, 0);
      cmd(8'h26, 8'h61, 0, 0);
      // A start byte in mid-command restarts the parse; a bad one drops it
      put(`PCR_CH_THR, 1);
      cmd(`PCR_CH_PULL, 8'h63, shadow[5], 1);
      put(`PCR_CH_DIR, 1);
      cmd(8'h26, 8'h61, 0, 0);
      // A register read earlier still holds its value
      cmd(`PCR_CH_DIR, 8'h61, shadow[0], 1);
      tally_and_finish;
   end
endmodule
